// *** inc/serial_tx_pkg.sv ***
// constants, register map and state types of the asynchronous serial transmitter
// ----------------------------------------------------------------------------
// Overview of operation
// - line idles at mark; mark is one, space is zero, no return to neutral
// - frame is one space start bit, eight or nine data bits, one mark stop bit
// - every bit stays on the line for exactly one bit period
// - bit rate comes from the system clock via an 8-bit or 16-bit divider
// - data bits leave least significant bit first
// - transmitter runs independently yet shares format and baud setting with receiver
// - no hardware parity; software may place parity in the ninth bit
// - sending only with transmit enable 1, sync 0, port enable 1; port enable drives pin
// - buffer-empty flag set while transmit enabled and no character waits in the holding register
// - writing the holding register starts sending; idle shifter loads at once
// - waiting character loads within one instruction cycle after the earlier stop bit
// - start, data and stop bits start shifting right after the load
// - polarity select 0 gives high-true line, 1 inverts it
// - polarity select inverts data in asynchronous mode only
// - exactly one pending character buffered in front of the shift register
// - character length programmable as 8 or 9 data bits
// - a 13-bit break character can be sent
// - control logic drives the pin direction itself, no software direction control; here tx_oe_n follows the port enable bit alone
// - buffer-empty clears while a character waits or transmit enable is 0
// - shift-register-empty flag is read-only, clear from load until all bits are out
// - nine-bit mode shifts ninth bit last; software writes it before the low byte
// ----------------------------------------------------------------------------
package serial_tx_pkg;

   // register word addresses (byte address = word * 4)
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_BAUD    = 4'h1;
   localparam logic [3:0] ADDR_DIVISOR = 4'h2;
   localparam logic [3:0] ADDR_DATA    = 4'h3;

   // transmit_control_register fields
   localparam int BIT_NINTH_DATA  = 0;
   localparam int BIT_SHIFT_EMPTY = 1;
   localparam int BIT_BREAK       = 3;
   localparam int BIT_SYNC        = 4;
   localparam int BIT_TX_ENABLE   = 5;
   localparam int BIT_NINE_SELECT = 6;
   localparam int BIT_PORT_ENABLE = 7;
   localparam int BIT_BUF_EMPTY   = 8;

   // baud_control_register fields
   localparam int BIT_WIDE_DIVIDER = 3;
   localparam int BIT_POLARITY     = 4;

   localparam int WIDTH_CHAR  = 8;
   localparam int BREAK_ZEROS = 12;
   localparam logic [15:0] DIVISOR_RESET = 16'h0000;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b11,
      ST_STOP  = 2'b10
   } tx_state_t;

   typedef struct packed {
      logic       tx_enable;
      logic       sync_mode;
      logic       port_enable;
      logic       nine_bit_select;
      logic       ninth_data_bit;
      logic       send_break;
      logic       polarity_select;
      logic       wide_divider;
      logic [15:0] divisor;
   } config_t;

endpackage

// *** rtl/baud_tick_gen.sv ***
// baud rate divider producing one-cycle bit ticks
`timescale 1ns/10ps
module baud_tick_gen #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   input  wire logic             run,
   input  wire logic             wide,
   input  wire logic [WIDTH-1:0] divisor,
   output logic                  tick
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } tick_state_t;

   tick_state_t s;
   tick_state_t next_s;
   logic [WIDTH-1:0] limit;

   always_comb begin
      next_s = s;
      limit  = wide ? divisor : {{(WIDTH-8){1'b0}}, divisor[7:0]};
      tick   = run && (s.count == '0);
      if (!run) begin
         next_s.count = limit;
      end else if (s.count == '0) begin
         next_s.count = limit;
      end else begin
         next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

endmodule

// *** rtl/async_serial_transmitter.sv ***
// transmit half of the enhanced serial port with Avalon-MM register access
`timescale 1ns/10ps
module async_serial_transmitter #(
   parameter int DIV_WIDTH = 16
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             tx_out,
   output logic             tx_oe_n,
   output logic             transmit_buffer_empty_flag,
   output logic             shift_register_empty_flag
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      serial_tx_pkg::config_t    cfg;
      logic [8:0]                holding;
      logic                      holding_full;
      logic                      holding_break;
      logic [8:0]                shifter;
      logic [3:0]                bit_left;
      logic                      nine_frame;
      logic                      break_frame;
      serial_tx_pkg::tx_state_t  state;
      logic                      line;
      logic                      acked;
      logic [31:0]               rdata;
   } tx_top_t;

   tx_top_t s;
   tx_top_t next_s;

   logic tick;
   logic active;
   logic access;
   logic wr;
   logic rd;
   logic shifter_idle;
   logic load;

   assign active       = s.cfg.tx_enable && !s.cfg.sync_mode && s.cfg.port_enable;
   assign access       = (avs_read || avs_write) && !s.acked;
   // a write lands only at the edge that ends the cycle after the wait cycle
   assign wr           = avs_write && s.acked;
   assign rd           = avs_read && !s.acked;
   assign shifter_idle = (s.state == serial_tx_pkg::ST_IDLE);

   // ------------------------------------------------------------
   // baud generator
   // ------------------------------------------------------------
   baud_tick_gen #(
      .WIDTH   (DIV_WIDTH)
   ) u_baud (
      .clk     (clk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .run     (active && !shifter_idle),
      .wide    (s.cfg.wide_divider),
      .divisor (s.cfg.divisor[DIV_WIDTH-1:0]),
      .tick    (tick)
   );

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      load   = 1'b0;

      // bus: one wait cycle, answer on the second
      next_s.acked = access;
      if (rd) begin
         next_s.rdata = '0;
         case (avs_address)
            serial_tx_pkg::ADDR_CONTROL: begin
               next_s.rdata[serial_tx_pkg::BIT_NINTH_DATA]  = s.cfg.ninth_data_bit;
               next_s.rdata[serial_tx_pkg::BIT_SHIFT_EMPTY] = shifter_idle;
               next_s.rdata[serial_tx_pkg::BIT_BREAK]       = s.cfg.send_break;
               next_s.rdata[serial_tx_pkg::BIT_SYNC]        = s.cfg.sync_mode;
               next_s.rdata[serial_tx_pkg::BIT_TX_ENABLE]   = s.cfg.tx_enable;
               next_s.rdata[serial_tx_pkg::BIT_NINE_SELECT] = s.cfg.nine_bit_select;
               next_s.rdata[serial_tx_pkg::BIT_PORT_ENABLE] = s.cfg.port_enable;
               next_s.rdata[serial_tx_pkg::BIT_BUF_EMPTY]   = s.cfg.tx_enable && !s.holding_full;
            end
            serial_tx_pkg::ADDR_BAUD: begin
               next_s.rdata[serial_tx_pkg::BIT_WIDE_DIVIDER] = s.cfg.wide_divider;
               next_s.rdata[serial_tx_pkg::BIT_POLARITY]     = s.cfg.polarity_select;
            end
            serial_tx_pkg::ADDR_DIVISOR: begin
               next_s.rdata[15:0] = s.cfg.divisor;
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end

      if (wr) begin
         case (avs_address)
            serial_tx_pkg::ADDR_CONTROL: begin
               if (avs_byteenable[0]) begin
                  next_s.cfg.ninth_data_bit  = avs_writedata[serial_tx_pkg::BIT_NINTH_DATA];
                  next_s.cfg.send_break      = avs_writedata[serial_tx_pkg::BIT_BREAK];
                  next_s.cfg.sync_mode       = avs_writedata[serial_tx_pkg::BIT_SYNC];
                  next_s.cfg.tx_enable       = avs_writedata[serial_tx_pkg::BIT_TX_ENABLE];
                  next_s.cfg.nine_bit_select = avs_writedata[serial_tx_pkg::BIT_NINE_SELECT];
                  next_s.cfg.port_enable     = avs_writedata[serial_tx_pkg::BIT_PORT_ENABLE];
               end
            end
            serial_tx_pkg::ADDR_BAUD: begin
               if (avs_byteenable[0]) begin
                  next_s.cfg.wide_divider    = avs_writedata[serial_tx_pkg::BIT_WIDE_DIVIDER];
                  next_s.cfg.polarity_select = avs_writedata[serial_tx_pkg::BIT_POLARITY];
               end
            end
            serial_tx_pkg::ADDR_DIVISOR: begin
               if (avs_byteenable[0]) begin
                  next_s.cfg.divisor[7:0] = avs_writedata[7:0];
               end
               if (avs_byteenable[1]) begin
                  next_s.cfg.divisor[15:8] = avs_writedata[15:8];
               end
            end
            serial_tx_pkg::ADDR_DATA: begin
               // ninth bit is taken as it stands at this write
               if (avs_byteenable[0] && !s.holding_full) begin
                  next_s.holding       = {s.cfg.ninth_data_bit, avs_writedata[7:0]};
                  next_s.holding_break = s.cfg.send_break;
                  next_s.holding_full  = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      // ------------------------------------------------------------
      // shifter
      // ------------------------------------------------------------
      if (!active) begin
         next_s.state = serial_tx_pkg::ST_IDLE;
      end else begin
         case (s.state)
            serial_tx_pkg::ST_IDLE: begin
               if (s.holding_full) begin
                  load = 1'b1;
               end
            end
            serial_tx_pkg::ST_START: begin
               if (tick) begin
                  next_s.state = serial_tx_pkg::ST_DATA;
               end
            end
            serial_tx_pkg::ST_DATA: begin
               if (tick) begin
                  next_s.shifter  = {1'b0, s.shifter[8:1]};
                  next_s.bit_left = s.bit_left - 1'b1;
                  if (s.bit_left == 4'h1) begin
                     next_s.state = serial_tx_pkg::ST_STOP;
                  end
               end
            end
            serial_tx_pkg::ST_STOP: begin
               if (tick) begin
                  next_s.state = serial_tx_pkg::ST_IDLE;
                  load = s.holding_full;
               end
            end
            default: begin
               next_s.state = serial_tx_pkg::ST_IDLE;
            end
         endcase
      end

      if (load) begin
         next_s.state        = serial_tx_pkg::ST_START;
         next_s.holding_full = 1'b0;
         next_s.break_frame  = s.holding_break;
         next_s.nine_frame   = s.cfg.nine_bit_select;
         if (s.holding_break) begin
            next_s.shifter  = '0;
            next_s.bit_left = 4'(serial_tx_pkg::BREAK_ZEROS);
         end else begin
            next_s.shifter  = s.holding;
            next_s.bit_left = s.cfg.nine_bit_select ? 4'(serial_tx_pkg::WIDTH_CHAR + 1)
                                                    : 4'(serial_tx_pkg::WIDTH_CHAR);
         end
      end

      // line level before polarity
      case (next_s.state)
         serial_tx_pkg::ST_START: next_s.line = 1'b0;
         serial_tx_pkg::ST_DATA:  next_s.line = next_s.shifter[0];
         default:                 next_s.line = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
         s.line <= 1'b1;
         s.cfg.divisor <= serial_tx_pkg::DIVISOR_RESET;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign avs_waitrequest = access;
   assign avs_readdata    = s.rdata;
   // polarity only in asynchronous mode
   assign tx_out  = s.line ^ (s.cfg.polarity_select && !s.cfg.sync_mode);
   assign tx_oe_n = !s.cfg.port_enable;
   assign transmit_buffer_empty_flag = s.cfg.tx_enable && !s.holding_full;
   assign shift_register_empty_flag  = shifter_idle;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_idle_mark;
      @(posedge clk) disable iff (!reset_n)
      (s.state == serial_tx_pkg::ST_IDLE) |-> (s.line == 1'b1);
   endproperty
   a_idle_mark: assert property (p_idle_mark) else $error("line not mark while idle");

   property p_start_space;
      @(posedge clk) disable iff (!reset_n)
      (s.state == serial_tx_pkg::ST_START) |-> (s.line == 1'b0);
   endproperty
   a_start_space: assert property (p_start_space) else $error("start bit not space");

   property p_load_starts;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && active && shifter_idle && s.holding_full)
         |=> (s.state == serial_tx_pkg::ST_START && !s.holding_full);
   endproperty
   a_load_starts: assert property (p_load_starts) else $error("idle shifter did not load");

   property p_back_to_back;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && active && tick && s.state == serial_tx_pkg::ST_STOP && s.holding_full)
         |=> (s.state == serial_tx_pkg::ST_START);
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("pending char not loaded");

   property p_lsb_shift;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && active && tick && s.state == serial_tx_pkg::ST_DATA && s.bit_left > 4'h1)
         |=> (s.line == $past(s.shifter[1]));
   endproperty
   a_lsb_shift: assert property (p_lsb_shift) else $error("data not shifted lsb first");

   property p_hold_bit;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && !tick && !load && active) |=> $stable(s.line);
   endproperty
   a_hold_bit: assert property (p_hold_bit) else $error("line changed without tick");

   property p_inactive_idle;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && !active) |=> shift_register_empty_flag;
   endproperty
   a_inactive_idle: assert property (p_inactive_idle) else $error("shifter ran while disabled");

   property p_empty_flag;
      @(posedge clk) disable iff (!reset_n)
      (s.cfg.tx_enable && shifter_idle && active && clk_en && !wr) |=> transmit_buffer_empty_flag;
   endproperty
   a_empty_flag: assert property (p_empty_flag) else $error("buffer-empty flag low while idle");

   property p_polarity;
      @(posedge clk) disable iff (!reset_n)
      (s.state == serial_tx_pkg::ST_IDLE && !s.cfg.sync_mode) |-> (tx_out == !s.cfg.polarity_select);
   endproperty
   a_polarity: assert property (p_polarity) else $error("idle level ignores polarity");

   // ------------------------------------------------------------
   // frame checks
   // ------------------------------------------------------------
   property p_stop_mark;
      @(posedge clk) disable iff (!reset_n)
      (s.state == serial_tx_pkg::ST_STOP) |-> (s.line == 1'b1);
   endproperty
   a_stop_mark: assert property (p_stop_mark) else $error("stop bit not mark");

   property p_char_length;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && load && !s.holding_break)
         |=> (s.bit_left == (s.nine_frame ? 4'(serial_tx_pkg::WIDTH_CHAR + 1) : 4'(serial_tx_pkg::WIDTH_CHAR)));
   endproperty
   a_char_length: assert property (p_char_length) else $error("wrong data bit count");

   property p_break_length;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && load && s.holding_break) |=> (s.bit_left == 4'(serial_tx_pkg::BREAK_ZEROS));
   endproperty
   a_break_length: assert property (p_break_length) else $error("break frame length wrong");

   property p_tick_advance;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && active && tick && s.state == serial_tx_pkg::ST_DATA) |=> (s.bit_left == $past(s.bit_left) - 4'h1);
   endproperty
   a_tick_advance: assert property (p_tick_advance) else $error("tick did not advance shifter");

   property p_refuse_full;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && wr && avs_address == serial_tx_pkg::ADDR_DATA && s.holding_full) |=> $stable(s.holding);
   endproperty
   a_refuse_full: assert property (p_refuse_full) else $error("full holding register overwritten");

   property p_load_busy;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && load) |=> !shift_register_empty_flag;
   endproperty
   a_load_busy: assert property (p_load_busy) else $error("shift empty flag set after load");

   property p_flag_valid;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && active && shifter_idle && wr && avs_address == serial_tx_pkg::ADDR_DATA && avs_byteenable[0])
         ##1 clk_en |=> transmit_buffer_empty_flag;
   endproperty
   a_flag_valid: assert property (p_flag_valid) else $error("buffer-empty flag not valid after write");

   property p_inactive_line;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && !active) |=> (s.line == 1'b1);
   endproperty
   a_inactive_line: assert property (p_inactive_line) else $error("line not mark while disabled");

   property p_sync_plain;
      @(posedge clk) disable iff (!reset_n)
      s.cfg.sync_mode |-> (tx_out == s.line);
   endproperty
   a_sync_plain: assert property (p_sync_plain) else $error("line inverted in synchronous mode");

endmodule

// *** verif/serial_rx_model.sv ***
// behavioural remote receiver watching the transmit line
`timescale 1ns/10ps
module serial_rx_model (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        listen,
   input  wire logic        line,
   input  wire logic        inv,
   input  wire logic [16:0] period,
   input  wire logic [3:0]  nbits,
   output logic             rx_start,
   output logic             rx_valid,
   output logic [11:0]      rx_data,
   output logic             rx_stop_ok,
   output logic             rx_phase_ok
);
   logic        busy;
   logic        first;
   logic        prev;
   logic [11:0] acc;
   logic        lv;
   int          cnt;
   int          ph;
   int          k;
   assign lv = line ^ inv;
   // sampling at whole periods after the fall tolerates any start length of 1..period
   always @(posedge clk) begin
      rx_start <= 1'b0;
      rx_valid <= 1'b0;
      k = cnt / period;
      if (!reset_n || !listen) begin
         busy <= 1'b0;
      end else if (!busy) begin
         if (lv === 1'b0) begin
            busy        <= 1'b1;
            cnt         <= 1;
            first       <= 1'b1;
            prev        <= 1'b0;
            acc         <= 12'h000;
            rx_phase_ok <= 1'b1;
            rx_start    <= 1'b1;
         end
      end else begin
         cnt  <= cnt + 1;
         prev <= lv;
         // every edge after the start bit must sit on the same bit phase
         if (lv !== prev) begin
            if (first) begin
               ph    <= cnt % period;
               first <= 1'b0;
            end else if (cnt % period != ph) begin
               rx_phase_ok <= 1'b0;
            end
         end
         if (cnt % period == 0) begin
            if (k <= nbits) begin
               acc[k-1] <= lv;
            end else begin
               rx_data    <= acc;
               rx_stop_ok <= (lv === 1'b1);
               rx_valid   <= 1'b1;
               busy       <= 1'b0;
            end
         end
      end
   end
endmodule

// *** verif/async_serial_transmitter_tb.sv ***
// self-checking bench of the asynchronous serial transmitter
`timescale 1ns/10ps
module async_serial_transmitter_tb;
   typedef struct packed {
      logic        wide;
      logic        inv;
      logic        nine;
      logic        ninth;
      logic [7:0]  data;
      logic [15:0] div;
   } row_t;
   localparam int NROWS = 8;
   logic        clk;
   logic        reset_n;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        tx_out;
   logic        tx_oe_n;
   logic        buf_empty;
   logic        shift_empty;
   logic        listen;
   logic        inv;
   logic [16:0] period;
   logic [3:0]  nbits;
   logic        rx_start;
   logic        rx_valid;
   logic [11:0] rx_data;
   logic        rx_stop_ok;
   logic        rx_phase_ok;
   logic [31:0] q;
   int          n_errors;
   int          check_count;
   int          cycles;
   int          p;
   int          i;
   int          bad;
   row_t        r;
   row_t        rows [NROWS];
   logic [3:0]  raddr [5];
   logic [31:0] rexp [5];

   async_serial_transmitter DUT (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_out(tx_out), .tx_oe_n(tx_oe_n),
      .transmit_buffer_empty_flag(buf_empty), .shift_register_empty_flag(shift_empty));
   serial_rx_model rx (.clk(clk), .reset_n(reset_n), .listen(listen), .line(tx_out), .inv(inv),
      .period(period), .nbits(nbits), .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_stop_ok(rx_stop_ok), .rx_phase_ok(rx_phase_ok));

   // ---------------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------------
   task end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int w;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (avs_waitrequest !== 1'b0 && w < 20);
      if (w >= 20) chk(32'h0, 32'h1);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // which: 0 frame start, 1 frame done, 2 shifter empty
   task wait_sig(input int which, input int lim, input logic want);
      int   t;
      logic s;
      t = 0;
      do begin
         @(posedge clk);
         t++;
         s = (which == 0) ? rx_start : (which == 1) ? rx_valid : shift_empty;
      end while (s !== 1'b1 && t < lim);
      chk(s, want);
   endtask

   function logic [31:0] ctl(input row_t x);
      return 32'h0A0 | {25'h0, x.nine, 5'h0, x.ninth};
   endfunction

   task cfg(input row_t x);
      listen <= 1'b0;
      inv    <= x.inv;
      nbits  <= x.nine ? 4'h9 : 4'h8;
      p = (x.wide ? x.div : {8'h00, x.div[7:0]}) + 1;
      period <= p[16:0];
      bus(1'b1, serial_tx_pkg::ADDR_BAUD, {27'h0, x.inv, x.wide, 3'h0});
      bus(1'b1, serial_tx_pkg::ADDR_DIVISOR, {16'h0, x.div});
      bus(1'b1, serial_tx_pkg::ADDR_CONTROL, ctl(x));
   endtask

   task send(input logic [7:0] d);
      listen <= 1'b1;
      bus(1'b1, serial_tx_pkg::ADDR_DATA, {24'h0, d});
   endtask

   // ---------------------------------------------------------------------
   // clock, timeout and sequence
   // ---------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test;
      end
   end

   initial begin
      rows = '{'{1'b0, 1'b0, 1'b0, 1'b0, 8'hA5, 16'h0003}, '{1'b0, 1'b0, 1'b1, 1'b1, 8'h3C, 16'h0002},
               '{1'b0, 1'b0, 1'b1, 1'b0, 8'hFF, 16'h0000}, '{1'b0, 1'b1, 1'b0, 1'b0, 8'h55, 16'h0004},
               '{1'b1, 1'b0, 1'b0, 1'b0, 8'h81, 16'h0102}, '{1'b0, 1'b0, 1'b0, 1'b0, 8'h81, 16'h0102},
               '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 16'h0001}, '{1'b1, 1'b1, 1'b0, 1'b0, 8'h0F, 16'h0010}};
      raddr = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF};
      rexp  = '{32'h0000_0002, 32'h0, {16'h0, serial_tx_pkg::DIVISOR_RESET}, 32'h0, 32'h0};
      {reset_n, avs_address, avs_read, avs_write, avs_writedata, listen, inv} = '0;
      {period, nbits, n_errors, check_count, cycles} = '0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      for (i = 0; i < NROWS; i++) begin
         r = rows[i];
         cfg(r);
         bus(1'b0, serial_tx_pkg::ADDR_CONTROL, 32'h0);
         chk(q, ctl(r) | 32'h0000_0102);
         chk(tx_oe_n, 1'b0);
         chk(tx_out, !r.inv);
         send(r.data);
         wait_sig(0, 20, 1'b1);
         chk(shift_empty, 1'b0);
         wait_sig(1, 14 * p, 1'b1);
         chk(rx_data, {3'h0, r.nine & r.ninth, r.data});
         chk(rx_stop_ok, 1'b1);
         chk(rx_phase_ok, 1'b1);
         wait_sig(2, 2 * p + 4, 1'b1);
         chk(buf_empty, 1'b1);
      end
      // back-to-back characters, third one refused while the holder is full
      cfg(rows[0]);
      send(8'h12);
      send(8'h34);
      repeat (2) @(posedge clk);
      chk(buf_empty, 1'b0);
      send(8'h56);
      wait_sig(1, 14 * p, 1'b1);
      chk(rx_data, 32'h012);
      wait_sig(0, p + 2, 1'b1);
      wait_sig(1, 14 * p, 1'b1);
      chk(rx_data, 32'h034);
      wait_sig(0, 12 * p, 1'b0);
      // break character: start plus twelve space bits, then stop
      bus(1'b1, serial_tx_pkg::ADDR_CONTROL, ctl(rows[0]) | 32'h008);
      nbits <= 4'hC;
      send(8'hFF);
      wait_sig(1, 16 * p, 1'b1);
      chk(rx_data, 32'h000);
      chk(rx_stop_ok, 1'b1);
      // synchronous select blocks sending and polarity inversion
      listen <= 1'b0;
      bus(1'b1, serial_tx_pkg::ADDR_CONTROL, 32'h0B0);
      bus(1'b1, serial_tx_pkg::ADDR_BAUD, 32'h010);
      bus(1'b1, serial_tx_pkg::ADDR_DATA, 32'h000);
      bad = 0;
      repeat (30) begin
         @(posedge clk);
         if (tx_out !== 1'b1) bad++;
      end
      chk(bad, 0);
      bus(1'b1, serial_tx_pkg::ADDR_CONTROL, 32'h030);
      @(posedge clk);
      chk(tx_oe_n, 1'b1);
      bus(1'b1, serial_tx_pkg::ADDR_CONTROL, 32'h080);
      repeat (2) @(posedge clk);
      chk(buf_empty, 1'b0);
      // reset with a character held and transmit disabled, then reset values and an unmapped address
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk({tx_out, tx_oe_n, buf_empty, shift_empty}, 32'hD);
      reset_n <= 1'b1;
      for (i = 0; i < 5; i++) begin
         bus(1'b0, raddr[i], 32'h0);
         chk(q, rexp[i]);
      end
      end_of_test;
   end
endmodule
